// *** src/gtc_defines.svh ***
`ifndef GTC_DEFINES_SVH
`define GTC_DEFINES_SVH

// Register indices on the plain register port
`define GTC_ADDR_COUNT_LOW   4'h0
`define GTC_ADDR_COUNT_HIGH  4'h1
`define GTC_ADDR_TIMER_CTRL  4'h2
`define GTC_ADDR_GATE_CTRL   4'h3
`define GTC_ADDR_CLK_SEL     4'h4
`define GTC_ADDR_GATE_SEL    4'h5
`define GTC_ADDR_FLAGS       4'h6
`define GTC_ADDR_IRQ_EN      4'h7

// Timer control fields
`define GTC_TC_ON            0
`define GTC_TC_SYNC_BYPASS   2
`define GTC_TC_PRESCALE_LO   4
`define GTC_TC_PRESCALE_HI   5

// Gate control fields
`define GTC_GC_GATE_VALUE_STATUS          2
`define GTC_GC_GO            3
`define GTC_GC_SPM           4
`define GTC_GC_TOGGLE        5
`define GTC_GC_POL           6
`define GTC_GC_ENABLE        7

// Flag and enable fields
`define GTC_FL_OVERFLOW      0
`define GTC_FL_GATE_EVENT    1

// Clock select codes
`define GTC_CS_EXT_PIN       4'h0
`define GTC_CS_INSTR         4'h1
`define GTC_CS_FULL_OSC      4'h2
`define GTC_CS_TMR0_OVF      4'h8

// Gate select codes
`define GTC_GS_PIN           5'h00
`define GTC_GS_TMR0_OVF      5'h01
`define GTC_GS_CMP1          5'h0D
`define GTC_GS_CMP2          5'h0E

// Full-rate oscillator cycles per instruction cycle
`define GTC_OSC_PER_INSTR    4

`endif

// *** src/gtc_pkg.sv ***
package gtc_pkg;
    typedef enum logic [1:0] {
        GTC_ARM_WAIT_FALL,
        GTC_ARM_READY
    } gtc_arm_t;

    typedef enum logic [1:0] {
        GTC_SP_IDLE,
        GTC_SP_ARMED,
        GTC_SP_ACTIVE
    } gtc_sp_t;
endpackage

// *** src/gtc_edge_sync.sv ***
`timescale 1ns/10ps
`include "gtc_defines.svh"

// Two-stage synchroniser with optional bypass and edge outputs
module gtc_edge_sync
    import gtc_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic bypass,
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic stage1;
    logic stage2;
    logic last;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
        end
    end

    // Bypass trades metastability margin for no added latency
    assign level = bypass ? din : stage2;

    // Previous level for edge detection
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            last <= 1'b0;
        end else begin
            last <= level;
        end
    end

    assign rise = level & ~last;
    assign fall = ~level & last;
endmodule

// *** src/gtc_timer.sv ***
`timescale 1ns/10ps
`include "gtc_defines.svh"

module gtc_timer
    import gtc_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int PS_W  = 2
)
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire logic       instr_tick,
    input  wire logic       ext_count_in,
    input  wire logic       tmr0_ovf_pulse,
    input  wire logic       gate_pin,
    input  wire logic       cmp1_out,
    input  wire logic       cmp2_out,
    output logic            overflow_flag,
    output logic            gate_event_flag,
    output logic            irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [CNT_W-1:0] count;
    logic [7:0]       timer_ctrl;
    logic [7:0]       gate_ctrl;
    logic [3:0]       clk_sel;
    logic [4:0]       gate_sel;
    logic [1:0]       irq_en;
    logic [PS_W+1:0]  prescale_cnt;
    logic             go_bit;
    logic             toggle_ff;
    gtc_arm_t         arm_state;
    gtc_sp_t          sp_state;

    logic timer_on;
    logic gate_en;
    logic wr_count;
    assign timer_on = timer_ctrl[`GTC_TC_ON];
    assign gate_en  = gate_ctrl[`GTC_GC_ENABLE];
    assign wr_count = reg_wr && (reg_addr == `GTC_ADDR_COUNT_LOW
                              || reg_addr == `GTC_ADDR_COUNT_HIGH);

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    // Level of the external input is unused; only its edges count
    logic ext_rise;
    logic ext_fall;
    logic bypass;
    assign bypass = timer_ctrl[`GTC_TC_SYNC_BYPASS];

    gtc_edge_sync u_ext_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .bypass  (bypass),
        .din     (ext_count_in),
        .level   (),
        .rise    (ext_rise),
        .fall    (ext_fall)
    );

    logic gate_raw;
    always_comb begin
        case (gate_sel)
            `GTC_GS_PIN:      gate_raw = gate_pin;
            `GTC_GS_TMR0_OVF: gate_raw = tmr0_ovf_pulse;
            `GTC_GS_CMP1:     gate_raw = cmp1_out;
            `GTC_GS_CMP2:     gate_raw = cmp2_out;
            default:          gate_raw = 1'b0;
        endcase
    end

    // Comparators may be asynchronous, so every gate source is synchronised
    logic gate_src;
    logic gate_src_rise;
    logic gate_src_fall;
    gtc_edge_sync u_gate_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .bypass  (1'b0),
        .din     (gate_raw),
        .level   (gate_src),
        .rise    (gate_src_rise),
        .fall    (gate_src_fall)
    );

    // Polarity applied before toggle; incrementing edge is active-going edge
    logic gate_pol_lvl;
    logic gate_inc_edge;
    assign gate_pol_lvl  = gate_ctrl[`GTC_GC_POL] ? gate_src : ~gate_src;
    assign gate_inc_edge = gate_ctrl[`GTC_GC_POL] ? gate_src_rise : gate_src_fall;

    // ------------------------------------------------------------
    // Gate toggle and single pulse
    // ------------------------------------------------------------
    // toggle flip-flop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            toggle_ff <= 1'b0;
        end else if (!gate_ctrl[`GTC_GC_TOGGLE] || !timer_on) begin
            toggle_ff <= 1'b0;
        end else if (gate_inc_edge) begin
            toggle_ff <= ~toggle_ff;
        end
    end

    logic toggled_lvl;
    assign toggled_lvl = gate_ctrl[`GTC_GC_TOGGLE] ? toggle_ff : gate_pol_lvl;

    logic toggled_last;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            toggled_last <= 1'b0;
        end else begin
            toggled_last <= toggled_lvl;
        end
    end

    logic tg_rise;
    logic tg_fall;
    assign tg_rise = toggled_lvl & ~toggled_last;
    assign tg_fall = ~toggled_lvl & toggled_last;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sp_state <= GTC_SP_IDLE;
        end else if (!gate_ctrl[`GTC_GC_SPM] || !go_bit) begin
            sp_state <= GTC_SP_IDLE;
        end else begin
            case (sp_state)
                GTC_SP_IDLE:   sp_state <= GTC_SP_ARMED;
                GTC_SP_ARMED:  if (tg_rise) sp_state <= GTC_SP_ACTIVE;
                GTC_SP_ACTIVE: if (tg_fall) sp_state <= GTC_SP_IDLE;
                default:       sp_state <= GTC_SP_IDLE;
            endcase
        end
    end

    // Go bit: software sets; hardware clears at trailing edge or when mode off
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            go_bit <= 1'b0;
        end else if (!gate_ctrl[`GTC_GC_SPM]) begin
            go_bit <= 1'b0;
        end else if (reg_wr && reg_addr == `GTC_ADDR_GATE_CTRL) begin
            go_bit <= reg_wdata[`GTC_GC_GO];
        end else if (sp_state == GTC_SP_ACTIVE && tg_fall) begin
            go_bit <= 1'b0;
        end
    end

    logic gate_value;
    assign gate_value = gate_ctrl[`GTC_GC_SPM] ? (sp_state == GTC_SP_ACTIVE && toggled_lvl)
                                               : toggled_lvl;

    logic gate_value_last;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gate_value_last <= 1'b0;
        end else begin
            gate_value_last <= gate_value;
        end
    end

    // ------------------------------------------------------------
    // Count enable and prescale
    // ------------------------------------------------------------
    // enable table
    logic count_allowed;
    assign count_allowed = timer_on && (!gate_en || gate_value);

    logic ext_mode;
    assign ext_mode = (clk_sel == `GTC_CS_EXT_PIN);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            arm_state <= GTC_ARM_WAIT_FALL;
        end else if (wr_count || !timer_on) begin
            arm_state <= GTC_ARM_WAIT_FALL;
        end else begin
            case (arm_state)
                GTC_ARM_WAIT_FALL: if (ext_fall) arm_state <= GTC_ARM_READY;
                GTC_ARM_READY:     arm_state <= GTC_ARM_READY;
                default:           arm_state <= GTC_ARM_WAIT_FALL;
            endcase
        end
    end

    logic src_tick;
    always_comb begin
        case (clk_sel)
            `GTC_CS_EXT_PIN:  src_tick = ext_rise && arm_state == GTC_ARM_READY;
            `GTC_CS_INSTR:    src_tick = instr_tick;
            `GTC_CS_FULL_OSC: src_tick = 1'b1;
            `GTC_CS_TMR0_OVF: src_tick = tmr0_ovf_pulse;
            default:          src_tick = 1'b0;
        endcase
    end

    logic [PS_W+1:0] ps_limit;
    always_comb begin
        case (timer_ctrl[`GTC_TC_PRESCALE_HI:`GTC_TC_PRESCALE_LO])
            2'h3:    ps_limit = 4'h7;
            2'h2:    ps_limit = 4'h3;
            2'h1:    ps_limit = 4'h1;
            default: ps_limit = 4'h0;
        endcase
    end

    logic ps_tick;
    assign ps_tick = count_allowed && src_tick && (prescale_cnt >= ps_limit);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prescale_cnt <= '0;
        end else if (wr_count) begin
            prescale_cnt <= '0;
        end else if (count_allowed && src_tick) begin
            prescale_cnt <= ps_tick ? '0 : prescale_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // byte-wise live count
    // full-rate oscillator: one count per system clock, i.e. four per instruction
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (reg_wr && reg_addr == `GTC_ADDR_COUNT_LOW) begin
            count[7:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == `GTC_ADDR_COUNT_HIGH) begin
            count[CNT_W-1:8] <= reg_wdata;
        end else if (ps_tick) begin
            count <= count + 1'b1;
        end
    end

    logic wrap;
    assign wrap = ps_tick && (count == {CNT_W{1'b1}}) && !wr_count;

    // ------------------------------------------------------------
    // Control registers and flags
    // ------------------------------------------------------------
    // Software-owned control bits
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timer_ctrl <= 8'h00;
            gate_ctrl  <= 8'h00;
            clk_sel    <= 4'h0;
            gate_sel   <= 5'h00;
            irq_en     <= 2'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `GTC_ADDR_TIMER_CTRL: timer_ctrl <= reg_wdata & 8'h35;
                `GTC_ADDR_GATE_CTRL:  gate_ctrl  <= reg_wdata & 8'hF0;
                `GTC_ADDR_CLK_SEL:    clk_sel    <= reg_wdata[3:0];
                `GTC_ADDR_GATE_SEL:   gate_sel   <= reg_wdata[4:0];
                `GTC_ADDR_IRQ_EN:     irq_en     <= reg_wdata[1:0];
                default:              irq_en     <= irq_en;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            overflow_flag <= 1'b0;
        end else if (wrap) begin
            overflow_flag <= 1'b1;
        end else if (reg_wr && reg_addr == `GTC_ADDR_FLAGS && reg_wdata[`GTC_FL_OVERFLOW]) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gate_event_flag <= 1'b0;
        end else if (!gate_value && gate_value_last) begin
            gate_event_flag <= 1'b1;
        end else if (reg_wr && reg_addr == `GTC_ADDR_FLAGS
                     && reg_wdata[`GTC_FL_GATE_EVENT]) begin
            gate_event_flag <= 1'b0;
        end
    end

    assign irq = (overflow_flag & irq_en[`GTC_FL_OVERFLOW])
               | (gate_event_flag & irq_en[`GTC_FL_GATE_EVENT]);

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // coherent byte read: single-clock count register is never mid-update
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `GTC_ADDR_COUNT_LOW:  reg_rdata <= count[7:0];
                `GTC_ADDR_COUNT_HIGH: reg_rdata <= count[CNT_W-1:8];
                `GTC_ADDR_TIMER_CTRL: reg_rdata <= timer_ctrl;
                `GTC_ADDR_GATE_CTRL:  reg_rdata <= {gate_ctrl[7:4], go_bit, gate_value, 2'b00};
                `GTC_ADDR_CLK_SEL:    reg_rdata <= {4'h0, clk_sel};
                `GTC_ADDR_GATE_SEL:   reg_rdata <= {3'h0, gate_sel};
                `GTC_ADDR_FLAGS:      reg_rdata <= {6'h00, gate_event_flag, overflow_flag};
                `GTC_ADDR_IRQ_EN:     reg_rdata <= {6'h00, irq_en};
                default:              reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_WRAP_SETS_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
        wrap |=> overflow_flag && count == '0)
        else $error("wrap did not set overflow flag");

    AST_OFF_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)
        (!timer_on && !wr_count) |=> $stable(count))
        else $error("counter moved while off");

    AST_GATE_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        (timer_on && gate_en && !gate_value && !wr_count) |=> $stable(count))
        else $error("counted with gate closed");

    AST_PS_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
        wr_count |=> prescale_cnt == '0)
        else $error("prescaler not cleared by count write");

    AST_TOGGLE_CLR: assert property (@(posedge sys_clk) disable iff (rst)
        !gate_ctrl[`GTC_GC_TOGGLE] |=> !toggle_ff)
        else $error("toggle flip-flop not held clear");

    AST_GATE_EVENT: assert property (@(posedge sys_clk) disable iff (rst)
        (gate_value_last && !gate_value) |=> gate_event_flag)
        else $error("gate fall did not set event flag");

    AST_GO_DONE: assert property (@(posedge sys_clk) disable iff (rst)
        (sp_state == GTC_SP_ACTIVE && tg_fall && !reg_wr) |=> !go_bit)
        else $error("go bit not cleared at trailing edge");

    AST_ARM_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
        wr_count |=> arm_state == GTC_ARM_WAIT_FALL)
        else $error("count write did not rearm falling edge");
endmodule

// *** tb/gtc_src_model.sv ***
`timescale 1ns/10ps

// ----------------------------------------
// Model of the on-chip sources around the timer
// ----------------------------------------
module gtc_src_model
#(
    parameter int T0_PER = 64
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic t0_run,
    output logic      instr_tick,
    output logic      tmr0_ovf_pulse
);
    logic [1:0] phase;
    logic [7:0] t0_cnt;

    // Instruction tick is one system cycle in four
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase      <= 2'h0;
            instr_tick <= 1'b0;
        end else begin
            phase      <= phase + 2'h1;
            instr_tick <= (phase == 2'h3);
        end
    end

    // overflow pulse train
    // Single-cycle pulses, spaced wide so the gate logic sees each one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            t0_cnt         <= 8'h00;
            tmr0_ovf_pulse <= 1'b0;
        end else begin
            t0_cnt         <= (t0_cnt == 8'(T0_PER - 1)) ? 8'h00 : t0_cnt + 8'h01;
            tmr0_ovf_pulse <= t0_run && (t0_cnt == 8'(T0_PER - 1));
        end
    end
endmodule

// *** tb/gated_16bit_timer_counter_tb.sv ***
`timescale 1ns/10ps
`include "gtc_defines.svh"

// ----------------------------------------
// Self-checking bench for the gated timer
// ----------------------------------------
module gated_16bit_timer_counter_tb;
    logic        sys_clk, rst, reg_wr, reg_rd, ext_count_in, gate_pin;
    logic        cmp1_out, cmp2_out, t0_run, instr_tick, tmr0_ovf_pulse;
    logic        overflow_flag, gate_event_flag, irq;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic [15:0] c;
    int          n_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;

    gtc_src_model src (.sys_clk(sys_clk), .rst(rst), .t0_run(t0_run),
        .instr_tick(instr_tick), .tmr0_ovf_pulse(tmr0_ovf_pulse));

    gtc_timer dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .instr_tick(instr_tick), .ext_count_in(ext_count_in),
        .tmr0_ovf_pulse(tmr0_ovf_pulse), .gate_pin(gate_pin), .cmp1_out(cmp1_out),
        .cmp2_out(cmp2_out), .overflow_flag(overflow_flag),
        .gate_event_flag(gate_event_flag), .irq(irq));

    // 20 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Hang guard, far above the few thousand cycles the tests need
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // ----------------------------------------
    // Register port and stimulus helpers
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic rd16(output logic [15:0] v);
        logic [7:0] lo, hi;
        rd(`GTC_ADDR_COUNT_LOW, lo);
        rd(`GTC_ADDR_COUNT_HIGH, hi);
        v = {hi, lo};
    endtask

    task automatic prep(input logic [3:0] cs, input logic [15:0] v);
        wr(`GTC_ADDR_TIMER_CTRL, 8'h00);
        wr(`GTC_ADDR_COUNT_LOW, v[7:0]);
        wr(`GTC_ADDR_COUNT_HIGH, v[15:8]);
        wr(`GTC_ADDR_CLK_SEL, cs);
    endtask

    // Slow pulses so the synchroniser never drops one
    task automatic pulse(input int n);
        repeat (n) begin
            repeat (6) @(posedge sys_clk);
            ext_count_in <= 1'b1;
            repeat (6) @(posedge sys_clk);
            ext_count_in <= 1'b0;
        end
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic gpulse(input int n);
        repeat (6) @(posedge sys_clk);
        gate_pin <= 1'b1;
        repeat (n) @(posedge sys_clk);
        gate_pin <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic gv(input logic e);
        rd(`GTC_ADDR_GATE_CTRL, d);
        chk({15'h0, d[`GTC_GC_GATE_VALUE_STATUS]}, {15'h0, e});
    endtask

    task automatic wait_t0();
        int n;
        n = 0;
        while (tmr0_ovf_pulse !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (6) @(posedge sys_clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], d);
            // Polarity 0 with the gate pin low leaves the gate open after reset
            chk({8'h00, d}, (a == `GTC_ADDR_GATE_CTRL) ? 16'h0004 : 16'h0000);
        end
        wr(4'hA, 8'hFF);
        rd(4'hA, d);
        chk({8'h00, d}, 16'h0000);
        chk({14'h0, overflow_flag, gate_event_flag}, 16'h0000);
        $display("test reset done");
    endtask

    // First rise after enable is never counted, so 9 pulses give 8
    task automatic t_presc();
        for (int b = 0; b < 2; b++) begin
            for (int k = 0; k < 4; k++) begin
                prep(`GTC_CS_EXT_PIN, 16'h0000);
                wr(`GTC_ADDR_TIMER_CTRL, {2'b00, k[1:0], 1'b0, b[0], 2'b01});
                pulse(9);
                wr(`GTC_ADDR_TIMER_CTRL, 8'h00);
                rd16(c);
                chk(c, 16'd8 >> k);
            end
        end
        $display("test prescale done");
    endtask

    task automatic t_ovf();
        wr(`GTC_ADDR_FLAGS, 8'h03);
        wr(`GTC_ADDR_IRQ_EN, 8'h01);
        prep(`GTC_CS_EXT_PIN, 16'hFFFF);
        wr(`GTC_ADDR_TIMER_CTRL, 8'h01);
        pulse(2);
        chk({14'h0, overflow_flag, irq}, 16'h0003);
        wr(`GTC_ADDR_TIMER_CTRL, 8'h00);
        rd16(c);
        chk(c, 16'h0000);
        rd(`GTC_ADDR_FLAGS, d);
        chk({8'h00, d}, 16'h0001);
        wr(`GTC_ADDR_IRQ_EN, 8'h00);
        wr(`GTC_ADDR_FLAGS, 8'h01);
        // Clear lands at the edge the write task returns on; look one edge later
        @(posedge sys_clk);
        chk({14'h0, overflow_flag, irq}, 16'h0000);
        $display("test overflow done");
    endtask

    // Both presets need 1024 system cycles to wrap
    task automatic t_wrap();
        logic [3:0]  cs[2];
        logic [15:0] pre[2];
        int          n;
        cs  = '{`GTC_CS_FULL_OSC, `GTC_CS_INSTR};
        pre = '{16'hFC00, 16'hFF00};
        for (int i = 0; i < 2; i++) begin
            prep(cs[i], pre[i]);
            wr(`GTC_ADDR_TIMER_CTRL, 8'h01);
            n = 0;
            while (overflow_flag !== 1'b1 && n < 1100) begin
                @(posedge sys_clk);
                n++;
            end
            chk({15'h0, n >= 1016 && n <= 1032}, 16'h0001);
            wr(`GTC_ADDR_TIMER_CTRL, 8'h00);
            wr(`GTC_ADDR_FLAGS, 8'h03);
        end
        $display("test wrap done");
    endtask

    task automatic t_gate();
        logic p;
        for (int i = 0; i < 2; i++) begin
            p = i[0];
            prep(`GTC_CS_EXT_PIN, 16'h0000);
            wr(`GTC_ADDR_GATE_CTRL, {1'b1, p, 6'h00});
            gate_pin <= p;
            wr(`GTC_ADDR_TIMER_CTRL, 8'h01);
            pulse(1);
            gate_pin <= ~p;
            pulse(4);
            gate_pin <= p;
            pulse(4);
            wr(`GTC_ADDR_TIMER_CTRL, 8'h00);
            pulse(2);
            rd16(c);
            chk(c, 16'h0004);
        end
        wr(`GTC_ADDR_GATE_CTRL, 8'h00);
        gate_pin <= 1'b0;
        $display("test gate done");
    endtask

    // Unselected sources sit at the opposite level
    task automatic t_src();
        logic [4:0] sel[3];
        sel = '{`GTC_GS_PIN, `GTC_GS_CMP1, `GTC_GS_CMP2};
        wr(`GTC_ADDR_TIMER_CTRL, 8'h01);
        wr(`GTC_ADDR_GATE_CTRL, 8'h40);
        for (int i = 0; i < 3; i++) begin
            wr(`GTC_ADDR_GATE_SEL, {3'h0, sel[i]});
            gate_pin <= (i == 0);
            cmp1_out <= (i == 1);
            cmp2_out <= (i == 2);
            repeat (6) @(posedge sys_clk);
            gv(1'b1);
            wr(`GTC_ADDR_FLAGS, 8'h03);
            gate_pin <= (i != 0);
            cmp1_out <= (i != 1);
            cmp2_out <= (i != 2);
            repeat (6) @(posedge sys_clk);
            gv(1'b0);
            chk({15'h0, gate_event_flag}, 16'h0001);
        end
        gate_pin <= 1'b0;
        cmp1_out <= 1'b0;
        cmp2_out <= 1'b0;
        wr(`GTC_ADDR_GATE_SEL, `GTC_GS_TMR0_OVF);
        wr(`GTC_ADDR_GATE_CTRL, 8'h60);
        t0_run <= 1'b1;
        wait_t0();
        gv(1'b1);
        wr(`GTC_ADDR_TIMER_CTRL, 8'h00);
        gv(1'b0);
        wr(`GTC_ADDR_TIMER_CTRL, 8'h01);
        wait_t0();
        gv(1'b1);
        wait_t0();
        gv(1'b0);
        wait_t0();
        wr(`GTC_ADDR_GATE_CTRL, 8'h40);
        gv(1'b0);
        t0_run <= 1'b0;
        wr(`GTC_ADDR_GATE_SEL, `GTC_GS_PIN);
        $display("test sources done");
    endtask

    task automatic t_sp();
        logic [15:0] c2;
        prep(`GTC_CS_FULL_OSC, 16'h0000);
        wr(`GTC_ADDR_GATE_CTRL, 8'hD0);
        wr(`GTC_ADDR_TIMER_CTRL, 8'h01);
        gpulse(20);
        rd16(c);
        chk(c, 16'h0000);
        wr(`GTC_ADDR_GATE_CTRL, 8'hD8);
        rd(`GTC_ADDR_GATE_CTRL, d);
        chk({15'h0, d[`GTC_GC_GO]}, 16'h0001);
        gpulse(20);
        rd16(c);
        chk({15'h0, c >= 16 && c <= 24}, 16'h0001);
        rd(`GTC_ADDR_GATE_CTRL, d);
        chk({15'h0, d[`GTC_GC_GO]}, 16'h0000);
        gpulse(20);
        rd16(c2);
        chk(c2, c);
        // Toggle plus single pulse: count spans one rise-to-rise period of 34 cycles
        prep(`GTC_CS_FULL_OSC, 16'h0000);
        wr(`GTC_ADDR_GATE_CTRL, 8'hF8);
        wr(`GTC_ADDR_TIMER_CTRL, 8'h01);
        gpulse(20);
        gpulse(20);
        rd16(c2);
        chk({15'h0, c2 >= 30 && c2 <= 38}, 16'h0001);
        wr(`GTC_ADDR_GATE_CTRL, 8'h00);
        wr(`GTC_ADDR_TIMER_CTRL, 8'h00);
        $display("test single pulse done");
    endtask

    // Main sequence
    initial begin
        rst          = 1'b1;
        reg_addr     = 4'h0;
        reg_wdata    = 8'h00;
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        ext_count_in = 1'b0;
        gate_pin     = 1'b0;
        cmp1_out     = 1'b0;
        cmp2_out     = 1'b0;
        t0_run       = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_presc();
        t_ovf();
        t_wrap();
        t_gate();
        t_src();
        t_sp();
        summarize();
    end
endmodule
